// [rtl/imcl_ctrl.sv]
// Control logic of a byte-oriented two-wire bus master: control register,
// request sequencing, holding register, baud timer and input filters.
// Assumes an AHB-Lite master on hclk and a bit-level engine on hclk.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "imcl_params.svh"

// Functional notes
// - Enable bit switches transmitter and receiver.
// - Start request self-clears after start or disable.
// - Writing zero clears pending requests only through the enable bit.
// - Start waits for a byte to send.
// - Start waits for current byte and acknowledge.
// - Pending stop goes out before start.
// - Stop issued after byte sent or received.
// - Stop request clears after stop or disable.
// - Disabled timer interrupts when counter reaches one.
// - Timer interrupt bit ignored while enabled.
// - Transmit interrupt and DMA gated by the TXI bit.
// - Not-acknowledge request answers next read byte.
// - Flush empties holding register, sets empty.
// - Flush bit always reads zero.
// - Filters reject pulses under one clock.
// - Filters add three clocks of latency.
// - Nack flag cleared only by start/stop.
// - Timer interval equals reload times clock period.
module imcl_ctrl (
    // Clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // AHB-Lite slave
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic [31:0]       hrdata,
    // Bit-level engine status, same clock
    input  wire logic         eng_start_done,
    input  wire logic         eng_stop_done,
    input  wire logic         eng_nak_done,
    input  wire logic         eng_byte_busy,
    input  wire logic         eng_shift_full,
    input  wire logic         eng_load_take,
    input  wire logic         eng_nack_event,
    // Bit-level engine control
    output logic              eng_enable,
    output logic              eng_start_go,
    output logic              eng_stop_go,
    output logic              eng_nak_go,
    output logic [7:0]        tx_byte,
    output logic              baud_tick,
    // Bus pins, asynchronous
    input  wire logic         scl_pin,
    input  wire logic         sda_pin,
    output logic              scl_filtered,
    output logic              sda_filtered,
    // Interrupts and DMA
    output logic              irq,
    output logic              tx_irq,
    output logic              tx_dma_req
);

    imcl_pkg::imcl_byte_type    ctrl_ff;
    imcl_pkg::imcl_byte_type    tx_byte_ff;
    imcl_pkg::imcl_reload_type  reload_ff;
    imcl_pkg::imcl_reload_type  baud_cnt_ff;
    imcl_pkg::imcl_index_type   dp_idx_ff;
    imcl_pkg::imcl_irq_type     irq_sts_ff;
    imcl_pkg::imcl_irq_type     irq_mask_ff;
    imcl_pkg::imcl_irq_type     irq_set;
    logic                       dp_valid_ff;
    logic                       dp_write_ff;
    logic                       tx_empty_ff;
    logic                       tx_empty_q_ff;
    logic                       nack_flag_ff;
    logic                       nack_q_ff;
    logic                       baud_tick_ff;
    logic                       nxt_enable;
    logic                       wr_ctrl;
    logic                       wr_any;
    logic                       baud_evt;
    logic [1:0]                 scl_sync_ff;
    logic [1:0]                 sda_sync_ff;
    logic [1:0]                 scl_dly_ff;
    logic [1:0]                 sda_dly_ff;
    logic                       scl_filt_ff;
    logic                       sda_filt_ff;

    function automatic logic idx_mapped(input imcl_pkg::imcl_index_type idx);
        idx_mapped = (idx == `IMCL_IDX_CTRL) || (idx == `IMCL_IDX_RELOAD) ||
                     (idx == `IMCL_IDX_STATUS) || (idx == `IMCL_IDX_DATA) ||
                     (idx == `IMCL_IDX_IRQ_STS) || (idx == `IMCL_IDX_IRQ_MASK);
    endfunction

    function automatic logic wr_hit(input imcl_pkg::imcl_index_type idx);
        wr_hit = dp_valid_ff && dp_write_ff && (dp_idx_ff == idx);
    endfunction

    // Bus slave: zero wait state, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_ff <= 1'b0;
            dp_write_ff <= 1'b0;
            dp_idx_ff   <= '0;
        end else if (hready) begin
            dp_valid_ff <= hsel && htrans[1] && (haddr[31:14] == 18'h00000) &&
                           (haddr[1:0] == 2'h0) && idx_mapped(haddr[13:2]);
            dp_write_ff <= hwrite;
            dp_idx_ff   <= haddr[13:2];
        end
    end

    assign wr_ctrl = wr_hit(`IMCL_IDX_CTRL);
    assign wr_any  = dp_valid_ff && dp_write_ff;

    // Read data from registers in the data phase, so a read right after
    // a write already sees the new value
    always_comb begin
        hrdata = 32'h00000000;
        if (dp_valid_ff && !dp_write_ff) begin
            case (dp_idx_ff)
                `IMCL_IDX_CTRL:     hrdata = {24'h000000, ctrl_ff};
                `IMCL_IDX_RELOAD:   hrdata = {16'h0000, reload_ff};
                `IMCL_IDX_STATUS:   hrdata = {29'h00000000, eng_byte_busy, nack_flag_ff, tx_empty_ff};
                `IMCL_IDX_DATA:     hrdata = {24'h000000, tx_byte_ff};
                `IMCL_IDX_IRQ_STS:  hrdata = {29'h00000000, irq_sts_ff};
                `IMCL_IDX_IRQ_MASK: hrdata = {29'h00000000, irq_mask_ff};
                default:            hrdata = 32'h00000000;
            endcase
        end
    end

    // Control register
    assign nxt_enable = wr_ctrl ? hwdata[`IMCL_B_ENABLE] : ctrl_ff[`IMCL_B_ENABLE];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= `IMCL_CTRL_RST;
        end else begin
            ctrl_ff[`IMCL_B_ENABLE] <= nxt_enable;
            ctrl_ff[`IMCL_B_FLUSH]  <= 1'b0;
            if (wr_ctrl) begin
                ctrl_ff[`IMCL_B_BAUD_TIMER_IRQ_ENABLE]   <= hwdata[`IMCL_B_BAUD_TIMER_IRQ_ENABLE];
                ctrl_ff[`IMCL_B_TXI]    <= hwdata[`IMCL_B_TXI];
                ctrl_ff[`IMCL_B_FILTER] <= hwdata[`IMCL_B_FILTER];
            end
            // Software may only set; engine done or disable clears; disable wins over set, set wins over done
            if (!nxt_enable)
                ctrl_ff[`IMCL_B_START] <= 1'b0;
            else if (wr_ctrl && hwdata[`IMCL_B_START])
                ctrl_ff[`IMCL_B_START] <= 1'b1;
            else if (eng_start_done)
                ctrl_ff[`IMCL_B_START] <= 1'b0;
            if (!nxt_enable)
                ctrl_ff[`IMCL_B_STOP] <= 1'b0;
            else if (wr_ctrl && hwdata[`IMCL_B_STOP])
                ctrl_ff[`IMCL_B_STOP] <= 1'b1;
            else if (eng_stop_done)
                ctrl_ff[`IMCL_B_STOP] <= 1'b0;
            if (!nxt_enable)
                ctrl_ff[`IMCL_B_NAK] <= 1'b0;
            else if (wr_ctrl && hwdata[`IMCL_B_NAK])
                ctrl_ff[`IMCL_B_NAK] <= 1'b1;
            else if (eng_nak_done)
                ctrl_ff[`IMCL_B_NAK] <= 1'b0;
        end
    end

    // Request sequencing towards the bit engine
    assign eng_enable   = ctrl_ff[`IMCL_B_ENABLE];
    assign eng_stop_go  = ctrl_ff[`IMCL_B_ENABLE] && ctrl_ff[`IMCL_B_STOP] &&
                          !eng_byte_busy;
    // Start needs a byte, an idle shifter and no stop still owed
    assign eng_start_go = ctrl_ff[`IMCL_B_ENABLE] && ctrl_ff[`IMCL_B_START] &&
                          !ctrl_ff[`IMCL_B_STOP] &&
                          !eng_byte_busy &&
                          (!tx_empty_ff || eng_shift_full);
    assign eng_nak_go   = ctrl_ff[`IMCL_B_ENABLE] && ctrl_ff[`IMCL_B_NAK];

    // Holding register; engine take sets empty and wins over a write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_empty_ff <= 1'b1;
            tx_byte_ff  <= `IMCL_BYTE_RST;
        end else if (wr_ctrl && hwdata[`IMCL_B_FLUSH]) begin
            tx_empty_ff <= 1'b1;
            tx_byte_ff  <= `IMCL_BYTE_RST;
        end else if (eng_load_take) begin
            tx_empty_ff <= 1'b1;
        end else if (wr_hit(`IMCL_IDX_DATA)) begin
            tx_empty_ff <= 1'b0;
            tx_byte_ff  <= hwdata[7:0];
        end
    end

    assign tx_byte    = tx_byte_ff;
    assign tx_irq     = tx_empty_ff && ctrl_ff[`IMCL_B_TXI];
    assign tx_dma_req = tx_empty_ff && ctrl_ff[`IMCL_B_TXI];

    // Nack flag: set wins over the start/stop write that clears it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            nack_flag_ff <= 1'b0;
        else if (eng_nack_event && !ctrl_ff[`IMCL_B_START] && !ctrl_ff[`IMCL_B_STOP])
            nack_flag_ff <= 1'b1;
        else if (wr_ctrl && (hwdata[`IMCL_B_START] || hwdata[`IMCL_B_STOP]))
            nack_flag_ff <= 1'b0;
    end

    // Baud reload value and down-counter; reload of zero never times out
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            reload_ff <= `IMCL_RELOAD_RST;
        else if (wr_hit(`IMCL_IDX_RELOAD))
            reload_ff <= hwdata[15:0];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            baud_cnt_ff  <= `IMCL_RELOAD_RST;
            baud_tick_ff <= 1'b0;
        end else begin
            if (baud_cnt_ff <= 16'h0001)
                baud_cnt_ff <= reload_ff;
            else
                baud_cnt_ff <= baud_cnt_ff - 16'h0001;
            baud_tick_ff <= (baud_cnt_ff == 16'h0001);
        end
    end

    assign baud_tick = baud_tick_ff;
    assign baud_evt  = !ctrl_ff[`IMCL_B_ENABLE] && ctrl_ff[`IMCL_B_BAUD_TIMER_IRQ_ENABLE] &&
                       (baud_cnt_ff == 16'h0001);

    // Sticky interrupt status, write one to clear, set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_empty_q_ff <= 1'b1;
            nack_q_ff     <= 1'b0;
        end else begin
            tx_empty_q_ff <= tx_empty_ff;
            nack_q_ff     <= nack_flag_ff;
        end
    end

    always_comb begin
        irq_set                = '0;
        irq_set[`IMCL_I_BAUD]  = baud_evt;
        irq_set[`IMCL_I_TXE]   = tx_empty_ff && !tx_empty_q_ff && ctrl_ff[`IMCL_B_TXI];
        irq_set[`IMCL_I_NACK]  = nack_flag_ff && !nack_q_ff;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_sts_ff  <= '0;
            irq_mask_ff <= `IMCL_MASK_RST;
        end else begin
            if (wr_hit(`IMCL_IDX_IRQ_STS))
                irq_sts_ff <= (irq_sts_ff & ~hwdata[`IMCL_IRQ_W-1:0]) | irq_set;
            else
                irq_sts_ff <= irq_sts_ff | irq_set;
            if (wr_hit(`IMCL_IDX_IRQ_MASK))
                irq_mask_ff <= hwdata[`IMCL_IRQ_W-1:0];
        end
    end

    assign irq = |(irq_sts_ff & irq_mask_ff);

    // Pin synchronisers, then optional glitch filter; a level must agree
    // on two samples, so a one-clock pulse never reaches the output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            scl_dly_ff  <= 2'h3;
            sda_dly_ff  <= 2'h3;
            scl_filt_ff <= 1'b1;
            sda_filt_ff <= 1'b1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_pin};
            sda_sync_ff <= {sda_sync_ff[0], sda_pin};
            scl_dly_ff  <= {scl_dly_ff[0], scl_sync_ff[1]};
            sda_dly_ff  <= {sda_dly_ff[0], sda_sync_ff[1]};
            if (scl_dly_ff[0] == scl_dly_ff[1])
                scl_filt_ff <= scl_dly_ff[1];
            if (sda_dly_ff[0] == sda_dly_ff[1])
                sda_filt_ff <= sda_dly_ff[1];
        end
    end

    assign scl_filtered = ctrl_ff[`IMCL_B_FILTER] ? scl_filt_ff : scl_sync_ff[1];
    assign sda_filtered = ctrl_ff[`IMCL_B_FILTER] ? sda_filt_ff : sda_sync_ff[1];

    // Checks
    chk_enable_follows: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctrl |=> (eng_enable == $past(hwdata[`IMCL_B_ENABLE])))
        else $error("enable does not follow written control bit");

    chk_start_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_ff[`IMCL_B_START] && eng_start_done && !(wr_ctrl && hwdata[`IMCL_B_START]))
        |=> !ctrl_ff[`IMCL_B_START])
        else $error("start request not cleared after start sent");

    chk_request_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_ff[`IMCL_B_START] && nxt_enable && !eng_start_done) |=> ctrl_ff[`IMCL_B_START])
        else $error("start request cleared by software");

    chk_start_needs_data: assert property (@(posedge hclk) disable iff (!hresetn)
        eng_start_go |-> (!tx_empty_ff || eng_shift_full))
        else $error("start issued with no byte to send");

    chk_byte_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
        eng_byte_busy |-> (!eng_start_go && !eng_stop_go))
        else $error("condition issued during a byte");

    chk_stop_first: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_ff[`IMCL_B_STOP] && ctrl_ff[`IMCL_B_START]) |-> !eng_start_go)
        else $error("start issued before pending stop");

    chk_stop_issue: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_ff[`IMCL_B_ENABLE] && ctrl_ff[`IMCL_B_STOP] && !eng_byte_busy) |-> eng_stop_go)
        else $error("stop not issued after byte");

    chk_disable_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(eng_enable) |-> (ctrl_ff[`IMCL_B_START:`IMCL_B_STOP] == 2'h0) && !ctrl_ff[`IMCL_B_NAK])
        else $error("requests survive disable");

    chk_timer_irq: assert property (@(posedge hclk) disable iff (!hresetn)
        (!eng_enable && ctrl_ff[`IMCL_B_BAUD_TIMER_IRQ_ENABLE] && baud_cnt_ff == 16'h0001) |=> irq_sts_ff[`IMCL_I_BAUD])
        else $error("timer event lost");

    chk_timer_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
        eng_enable |-> !irq_set[`IMCL_I_BAUD])
        else $error("timer event while enabled");

    chk_tx_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctrl_ff[`IMCL_B_TXI] |-> (!tx_irq && !tx_dma_req))
        else $error("transmit request without enable");

    chk_nak_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_ff[`IMCL_B_NAK] && eng_nak_done && !(wr_ctrl && hwdata[`IMCL_B_NAK]))
        |=> !ctrl_ff[`IMCL_B_NAK])
        else $error("nak request not cleared");

    chk_flush_empty: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_ctrl && hwdata[`IMCL_B_FLUSH]) |=> (tx_empty_ff && tx_byte_ff == `IMCL_BYTE_RST))
        else $error("flush did not empty holding register");

    chk_flush_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (dp_valid_ff && !dp_write_ff && dp_idx_ff == `IMCL_IDX_CTRL) |-> !hrdata[`IMCL_B_FLUSH])
        else $error("flush bit read as one");

    chk_filter_latency: assert property (@(posedge hclk) disable iff (!hresetn)
        ($rose(scl_sync_ff[1]) && !scl_filt_ff && ctrl_ff[`IMCL_B_FILTER]) ##1
        (scl_sync_ff[1] && ctrl_ff[`IMCL_B_FILTER]) [*2] |-> !scl_filtered ##1 scl_filtered)
        else $error("filter latency is not three clocks");

    chk_glitch_reject: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_ff[`IMCL_B_FILTER] && sda_filt_ff && $fell(sda_sync_ff[1])) ##1
        (sda_sync_ff[1] && ctrl_ff[`IMCL_B_FILTER]) [*3] |-> sda_filtered)
        else $error("one-clock pulse passed the filter");

    chk_nack_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (nack_flag_ff && !(wr_ctrl && (hwdata[`IMCL_B_START] || hwdata[`IMCL_B_STOP])))
        |=> nack_flag_ff)
        else $error("nack flag cleared without start or stop");

    chk_reload_period: assert property (@(posedge hclk) disable iff (!hresetn)
        (baud_cnt_ff == 16'h0001 && reload_ff == 16'h0004 && !wr_hit(`IMCL_IDX_RELOAD))
        |=> baud_cnt_ff == 16'h0004 ##3 baud_cnt_ff == 16'h0001)
        else $error("timer interval differs from reload");

    chk_reset_zero: assert property (@(posedge hclk)
        !hresetn |-> (ctrl_ff == `IMCL_CTRL_RST))
        else $error("control register not zero in reset");

    cov_start_sent: cover property (@(posedge hclk) disable iff (!hresetn)
        eng_start_go ##[1:20] eng_start_done);
    cov_stop_then_start: cover property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_ff[`IMCL_B_STOP] && ctrl_ff[`IMCL_B_START]) ##[1:50] eng_start_go);
    cov_timer_irq: cover property (@(posedge hclk) disable iff (!hresetn)
        irq_set[`IMCL_I_BAUD] ##1 irq);

endmodule

// [shared/imcl_params.svh]
// Constants for the two-wire master control logic: register indices,
// bit positions, reset values and timing counts.
// Included by the package and by the design file.
`ifndef IMCL_PARAMS_SVH
`define IMCL_PARAMS_SVH

// Register indices; byte address is four times the index
`define IMCL_IDX_CTRL      12'hf52
`define IMCL_IDX_RELOAD    12'hf58
`define IMCL_IDX_STATUS    12'hf59
`define IMCL_IDX_DATA      12'hf5a
`define IMCL_IDX_IRQ_STS   12'hf5b
`define IMCL_IDX_IRQ_MASK  12'hf5c

// Control register bits
`define IMCL_B_ENABLE      7
`define IMCL_B_START       6
`define IMCL_B_STOP        5
`define IMCL_B_BAUD_TIMER_IRQ_ENABLE        4
`define IMCL_B_TXI         3
`define IMCL_B_NAK         2
`define IMCL_B_FLUSH       1
`define IMCL_B_FILTER      0

// Status register bits
`define IMCL_S_TXE         0
`define IMCL_S_NACK        1
`define IMCL_S_BUSY        2

// Interrupt status and mask bits
`define IMCL_I_BAUD        0
`define IMCL_I_TXE         1
`define IMCL_I_NACK        2
`define IMCL_IRQ_W         3

// Reset values
`define IMCL_CTRL_RST      8'h00
`define IMCL_RELOAD_RST    16'hffff
`define IMCL_MASK_RST      3'h0
`define IMCL_BYTE_RST      8'h00

// Input filter latency in system clocks
`define IMCL_FILT_LAT      3

`endif

// [shared/imcl_pkg.sv]
// Types shared by the two-wire master control logic.
// Assumes imcl_params.svh is on the include path.
`include "imcl_params.svh"
package imcl_pkg;
    typedef logic [7:0]              imcl_byte_type;
    typedef logic [15:0]             imcl_reload_type;
    typedef logic [11:0]             imcl_index_type;
    typedef logic [`IMCL_IRQ_W-1:0]  imcl_irq_type;
endpackage

// [tb/imcl_eng_model.sv]
// Behavioural bit-level engine: answers go levels with one-cycle done pulses.
// Assumes the control logic's hclk domain; lat sets how slowly it answers.
`timescale 1ns/1ps
module imcl_eng_model (
    // Clock, reset and pacing
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [1:0] lat,
    input  wire logic       busy_in,
    // Requests
    input  wire logic       start_go,
    input  wire logic       stop_go,
    input  wire logic       nak_go,
    // Answers
    output logic            start_done,
    output logic            stop_done,
    output logic            nak_done,
    output logic            byte_busy,
    output logic            load_take
);
    logic [1:0] cnt_ff;
    assign byte_busy = busy_in;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= 2'h0;
            {start_done, stop_done, nak_done, load_take} <= 4'h0;
        end else begin
            {start_done, stop_done, nak_done, load_take} <= 4'h0;
            // Rest one cycle after an answer: the go level falls an edge late
            if (start_done | stop_done | nak_done | !(start_go | stop_go | nak_go)) begin
                cnt_ff <= 2'h0;
            end else if (cnt_ff >= lat) begin
                start_done <= start_go;
                load_take  <= start_go;
                stop_done  <= stop_go;
                nak_done   <= nak_go;
                cnt_ff     <= 2'h0;
            end else begin
                cnt_ff <= cnt_ff + 2'h1;
            end
        end
    end
endmodule

// [tb/tb.sv]
// Self-checking bench for the two-wire master control logic.
// Assumes the engine model beside it and zero-wait bus answers.
`timescale 1ns/1ps
`include "imcl_params.svh"
module tb;
    localparam logic [11:0] CT = `IMCL_IDX_CTRL, RL = `IMCL_IDX_RELOAD, ST = `IMCL_IDX_STATUS;
    localparam logic [11:0] DT = `IMCL_IDX_DATA, IS = `IMCL_IDX_IRQ_STS, MK = `IMCL_IDX_IRQ_MASK;
    logic        hclk, hresetn, hwrite, hready, hresp, scl_pin, sda_pin, busy_in, eng_enable, shift_full;
    logic        start_go, stop_go, nak_go, start_done, stop_done, nak_done, byte_busy, load_take;
    logic        baud_tick, scl_f, sda_f, irq, tx_irq, tx_dma_req;
    logic [1:0]  htrans, lat;
    logic [7:0]  tx_byte;
    logic [31:0] haddr, hwdata, hrdata, q;
    int          mismatches, tests_run, cyc, ctl_m, r, t0;
    int          order_q[$];
    imcl_ctrl dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
        .hreadyout(hready), .hresp, .hrdata, .eng_start_done(start_done), .eng_stop_done(stop_done),
        .eng_nak_done(nak_done), .eng_byte_busy(byte_busy), .eng_shift_full(shift_full), .eng_load_take(load_take),
        .eng_nack_event(nak_done), .eng_enable, .eng_start_go(start_go), .eng_stop_go(stop_go),
        .eng_nak_go(nak_go), .tx_byte, .baud_tick, .scl_pin, .sda_pin, .scl_filtered(scl_f),
        .sda_filtered(sda_f), .irq, .tx_irq, .tx_dma_req);
    imcl_eng_model eng (.hclk, .hresetn, .lat, .busy_in, .start_go, .stop_go, .nak_go, .start_done,
        .stop_done, .nak_done, .byte_busy, .load_take);
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // First baud tick needs a full 16-bit count from reset
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (start_done) order_q.push_back(1);
        if (stop_done) order_q.push_back(2);
        if (cyc == 90000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic xfer(input logic [11:0] ix, input logic w, input logic [31:0] d);
        @(posedge hclk);
        haddr <= {18'h0, ix, 2'h0};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        #1;
    endtask
    task automatic rd(input string nm, input logic [11:0] ix, input logic [31:0] e);
        xfer(ix, 1'b0, 32'h0);
        chk(nm, e, q);
        chk("hresp", 32'h0, hresp);
    endtask
    task automatic poll(input logic [31:0] e);
        for (int i = 0; i < 20 && q !== e; i++) xfer(CT, 1'b0, 32'h0);
        chk("ctrl", e, q);
    endtask
    task automatic gap(input int lim, output int n);
        n = 0;
        do begin
            @(posedge hclk);
            #1;
            n++;
        end while (baud_tick !== 1'b1 && n < lim);
    endtask
    task automatic lag(output int n);
        @(posedge hclk);
        sda_pin <= ~sda_pin;
        n = 0;
        do begin
            @(posedge hclk);
            #1;
            n++;
        end while (sda_f !== sda_pin && n < 20);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        {hresetn, hwrite, scl_pin, sda_pin, busy_in, shift_full, htrans, lat, haddr, hwdata} = {6'b001100, 68'h0};
        void'($urandom(32'hbd29));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rd("ctrl", CT, 32'h0);
        rd("status", ST, 32'h1);
        rd("unmapped", 12'hf60, 32'h0);
        r = $urandom_range(12, 4);
        xfer(RL, 1'b1, r);
        rd("reload", RL, r);
        repeat (4) begin
            ctl_m = $urandom & 32'h9b;
            xfer(CT, 1'b1, ctl_m);
            rd("ctrl", CT, ctl_m & 32'h99);
            chk("enable", ctl_m >> 7, eng_enable);
            chk("tx_irq", ((ctl_m >> 3) & 1) * 3, {tx_dma_req, tx_irq});
        end
        $display("test reset and access done");
        lat = 2'($urandom_range(3));
        xfer(CT, 1'b1, 32'hc0);
        repeat (8) @(posedge hclk);
        chk("start_go", 32'h0, start_go);
        xfer(CT, 1'b1, 32'h80);
        rd("ctrl", CT, 32'hc0);
        t0 = $urandom & 32'hff;
        xfer(DT, 1'b1, t0);
        chk("tx_byte", t0, tx_byte);
        poll(32'h80);
        chk("start first", 1, order_q.pop_front());
        $display("test start done");
        busy_in <= 1'b1;
        xfer(DT, 1'b1, $urandom & 32'hff);
        xfer(CT, 1'b1, 32'he0);
        repeat (8) @(posedge hclk);
        chk("go", 32'h0, {start_go, stop_go});
        busy_in <= 1'b0;
        poll(32'h80);
        chk("first", 2, order_q.pop_front());
        chk("second", 1, order_q.pop_front());
        $display("test stop then start done");
        xfer(MK, 1'b1, 32'h7);
        xfer(CT, 1'b1, 32'h84);
        poll(32'h80);
        rd("status", ST, 32'h3);
        chk("irq", 1, irq);
        xfer(CT, 1'b1, 32'ha0);
        poll(32'h80);
        rd("status", ST, 32'h1);
        xfer(IS, 1'b1, 32'h7);
        rd("irq_sts", IS, 32'h0);
        busy_in <= 1'b1;
        xfer(CT, 1'b1, 32'he0);
        xfer(CT, 1'b1, 32'h0);
        rd("ctrl", CT, 32'h0);
        busy_in <= 1'b0;
        shift_full <= 1'b1;
        xfer(CT, 1'b1, 32'hc0);
        poll(32'h80);
        shift_full <= 1'b0;
        $display("test nak and disable done");
        xfer(DT, 1'b1, 32'h5a);
        rd("status", ST, 32'h0);
        xfer(CT, 1'b1, 32'h02);
        rd("status", ST, 32'h1);
        chk("tx_byte", 32'h0, tx_byte);
        xfer(CT, 1'b1, 32'h10);
        gap(70000, t0);
        gap(100, t0);
        chk("interval", r, t0);
        chk("irq", 1, irq);
        xfer(CT, 1'b1, 32'h90);
        xfer(IS, 1'b1, 32'h7);
        repeat (3 * r) @(posedge hclk);
        rd("irq_sts", IS, 32'h0);
        xfer(CT, 1'b1, 32'h00);
        xfer(IS, 1'b1, 32'h7);
        repeat (3 * r) @(posedge hclk);
        rd("irq_sts", IS, 32'h0);
        $display("test flush and timer done");
        lag(r);
        xfer(CT, 1'b1, 32'h01);
        lag(t0);
        chk("lag", r + 3, t0);
        t0 = sda_f;
        @(posedge hclk);
        sda_pin <= ~sda_pin;
        @(posedge hclk);
        sda_pin <= ~sda_pin;
        repeat (10) begin
            @(posedge hclk);
            #1;
            chk("glitch", t0, sda_f);
        end
        r = 0;
        t0 = scl_f;
        fork
            repeat (8) #24 scl_pin = ~scl_pin;
            repeat (60) begin
                @(posedge hclk);
                #1;
                if (scl_f !== t0[0]) r++;
                t0 = scl_f;
            end
        join
        chk("scl_edges", 8, r);
        $display("test filter done");
        summarize();
    end
endmodule
